// ===== include/bao_defs.svh
`ifndef BAO_DEFS_SVH
`define BAO_DEFS_SVH

// Widths and sizes.
`define BAO_DATA_W       8
`define BAO_IDX_W        5
`define BAO_ADDR_W       6
`define BAO_NUM_REGS     32
`define BAO_NUM_RD       3

// Register port map: working registers sit at 0x00..0x1f.
`define BAO_ADDR_FLAGS   6'h20
`define BAO_ADDR_STATUS  6'h21

// Flag register layout.
`define BAO_FLAG_C       0
`define BAO_FLAG_Z       1
`define BAO_FLAG_N       2
`define BAO_FLAG_V       3
`define BAO_FLAG_S       4
`define BAO_FLAG_H       5
`define BAO_FLAGS_RST    8'h00
`define BAO_FLAGS_WMASK  8'h3f

// Status register layout.
`define BAO_STAT_BUSY    0
`define BAO_STAT_CYC_LO  1
`define BAO_STAT_CYC_HI  2

// Byte constants used by the datapath.
`define BAO_ALL_ONES     8'hff
`define BAO_ZERO_BYTE    8'h00
`define BAO_ONE_BYTE     8'h01
`define BAO_SIGN_MIN     8'h80
`define BAO_SIGN_MAX     8'h7f

// Fixed product destination pair.
`define BAO_PROD_LO      5'h00
`define BAO_PROD_HI      5'h01

// Cycle counts reported per operation.
`define BAO_CYC_NONE     2'h0
`define BAO_CYC_ONE      2'h1
`define BAO_CYC_TWO      2'h2

`endif

// ===== include/bao_pkg.sv
`include "bao_defs.svh"

package bao_pkg;

  typedef enum logic [4:0] {
    OP_PLUS_TWO_REGS         = 5'h00,
    OP_PLUS_WITH_CARRY_IN    = 5'h01,
    OP_WORD_PLUS_IMM         = 5'h02,
    OP_MINUS_TWO_REGS        = 5'h03,
    OP_MINUS_IMM             = 5'h04,
    OP_MINUS_WITH_BORROW     = 5'h05,
    OP_MINUS_IMM_WITH_BORROW = 5'h06,
    OP_WORD_MINUS_IMM        = 5'h07,
    OP_BITWISE_CONJ          = 5'h08,
    OP_BITWISE_CONJ_IMM      = 5'h09,
    OP_BITWISE_DISJ          = 5'h0a,
    OP_BITWISE_DISJ_IMM      = 5'h0b,
    OP_BITWISE_XDISJ         = 5'h0c,
    OP_ONES_INVERT           = 5'h0d,
    OP_TWOS_INVERT           = 5'h0e,
    OP_BIT_SET_MASK          = 5'h0f,
    OP_BIT_CLEAR_MASK        = 5'h10,
    OP_PLUS_ONE              = 5'h11,
    OP_MINUS_ONE             = 5'h12,
    OP_ZERO_SIGN_PROBE       = 5'h13,
    OP_SELF_XDISJ_ZERO       = 5'h14,
    OP_ALL_ONES_LOAD         = 5'h15,
    OP_UNSIGNED_PRODUCT      = 5'h16,
    OP_SIGNED_PRODUCT        = 5'h17
  } bao_op_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_EXEC2 = 2'b11
  } bao_state_type;

  typedef struct packed {
    bao_state_type                st;
    bao_op_type                   op;
    logic [`BAO_IDX_W-1:0]        dst;
    logic [`BAO_DATA_W-1:0]       imm;
    logic [`BAO_DATA_W-1:0]       flags;
    logic [`BAO_IDX_W-1:0]        hi_idx;
    logic [`BAO_DATA_W-1:0]       hi_byte;
    logic                         done;
    logic [1:0]                   cycles;
    logic                         rd_mem;
    logic [`BAO_DATA_W-1:0]       rd_byte;
  } bao_regs_type;

  typedef struct packed {
    logic [`BAO_NUM_REGS-1:0][`BAO_DATA_W-1:0] mem;
    logic [`BAO_NUM_RD-1:0][`BAO_DATA_W-1:0]   rd;
  } bao_mem_type;

endpackage : bao_pkg

// ===== hw/bao_regfile.sv
`include "bao_defs.svh"

module bao_regfile
  import bao_pkg::*;
(
  // Clock and reset.
  input  wire logic                                       clk,
  input  wire logic                                       rst,
  // Write port.
  input  wire logic                                       wr_en,
  input  wire logic [`BAO_IDX_W-1:0]                      wr_idx,
  input  wire logic [`BAO_DATA_W-1:0]                     wr_data,
  // Read ports, data one cycle after the index.
  input  wire logic [`BAO_NUM_RD-1:0][`BAO_IDX_W-1:0]     rd_idx,
  output logic      [`BAO_NUM_RD-1:0][`BAO_DATA_W-1:0]    rd_data
);

  bao_mem_type q;
  bao_mem_type n;

  ////////////////////////////////////////////////////////////////////////////

  // A read of the word being written returns the new value, so a result is
  // visible to the very next operation without a stall.
  always_comb begin
    n = q;
    if (wr_en) begin
      n.mem[wr_idx] = wr_data;
    end
    for (int i = 0; i < `BAO_NUM_RD; i++) begin
      if (wr_en && (rd_idx[i] == wr_idx)) begin
        n.rd[i] = wr_data;
      end else begin
        n.rd[i] = q.mem[rd_idx[i]];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  genvar g;
  generate
    for (g = 0; g < `BAO_NUM_RD; g++) begin : g_rd
      assign rd_data[g] = q.rd[g];
    end
  endgenerate

endmodule : bao_regfile

// ===== hw/bao_alu.sv
`include "bao_defs.svh"

// Contract
// - Add two registers, optionally plus carry; flags Z C N V H; 1 cycle.
// - Add immediate to register pair, low first; Z C N V S; 2 cycles.
// - Subtract register or immediate from destination; Z C N V H; 1 cycle.
// - Subtract register and carry from destination; Z C N V H; 1 cycle.
// - Subtract immediate and carry from destination; Z C N V H; 1 cycle.
// - Subtract immediate from a register pair; flags Z C N V S; 2 cycles.
// - AND with register or immediate; flags Z N V only; 1 cycle.
// - OR, immediate OR, XOR, and self-XOR clear; flags Z N V; 1 cycle.
// - OR an immediate mask into destination; flags Z N V; 1 cycle.
// - AND destination with 0xFF minus mask; flags Z N V; 1 cycle.
// - AND register with itself, value kept; flags Z N V; 1 cycle.
module bao_alu
  import bao_pkg::*;
(
  // Clock and reset.
  input  wire logic                        MCLK,
  input  wire logic                        RST,
  // Operation request from the decoder.
  input  wire logic                        OP_START,
  input  wire logic [4:0]                  OP_CODE,
  input  wire logic [`BAO_IDX_W-1:0]       OP_DST,
  input  wire logic [`BAO_IDX_W-1:0]       OP_SRC,
  input  wire logic [`BAO_DATA_W-1:0]      OP_IMM,
  output logic                             OP_READY,
  output logic                             OP_DONE,
  output logic [1:0]                       OP_CYCLES,
  // Register port.
  input  wire logic [`BAO_ADDR_W-1:0]      REG_ADDR,
  input  wire logic [`BAO_DATA_W-1:0]      REG_WDATA,
  input  wire logic                        REG_WR,
  input  wire logic                        REG_RD,
  output logic [`BAO_DATA_W-1:0]           REG_RDATA,
  // Live flag register.
  output logic [`BAO_DATA_W-1:0]           FLAGS
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic is_work_addr(input logic [`BAO_ADDR_W-1:0] a);
    is_work_addr = (a < `BAO_ADDR_W'(`BAO_NUM_REGS));
  endfunction : is_work_addr

  function automatic logic is_pair_op(input logic [4:0] code);
    is_pair_op = (code == OP_WORD_PLUS_IMM) || (code == OP_WORD_MINUS_IMM);
  endfunction : is_pair_op

  // Returns {h, v, c, result}.
  function automatic logic [10:0] add8(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic       cin);
    logic [8:0] s9;
    logic [4:0] h5;
    s9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    h5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    add8 = {h5[4], (a[7] & b[7] & ~s9[7]) | (~a[7] & ~b[7] & s9[7]),
            s9[8], s9[7:0]};
  endfunction : add8

  // Returns {h, v, c, result}; c and h are borrows.
  function automatic logic [10:0] sub8(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic       cin);
    logic [8:0] d9;
    logic [4:0] h5;
    d9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    h5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    sub8 = {h5[4], (a[7] & ~b[7] & ~d9[7]) | (~a[7] & b[7] & d9[7]),
            d9[8], d9[7:0]};
  endfunction : sub8

  ////////////////////////////////////////////////////////////////////////////

  bao_regs_type                                q;
  bao_regs_type                                n;
  logic                                        wr_en;
  logic [`BAO_IDX_W-1:0]                       wr_idx;
  logic [`BAO_DATA_W-1:0]                      wr_data;
  logic [`BAO_NUM_RD-1:0][`BAO_IDX_W-1:0]      rd_idx;
  logic [`BAO_NUM_RD-1:0][`BAO_DATA_W-1:0]     rd_data;

  bao_regfile u_regs (
    .clk     (MCLK),
    .rst     (RST),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .rd_idx  (rd_idx),
    .rd_data (rd_data)
  );

  // Port 0 fetches the destination, port 1 the source or the pair's high
  // byte, port 2 serves the register port. Indices follow the request pins
  // every cycle; only the ones seen in the accepting cycle are consumed.
  always_comb begin
    rd_idx[0] = OP_DST;
    rd_idx[1] = is_pair_op(OP_CODE) ? OP_DST + `BAO_IDX_W'(1) : OP_SRC;
    rd_idx[2] = REG_ADDR[`BAO_IDX_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////

  logic [7:0]  opa;
  logic [7:0]  opb;
  logic        cf;
  logic [7:0]  res;
  logic [10:0] ar;
  logic [15:0] w16;
  logic [16:0] w17;
  logic [15:0] prod;
  logic [7:0]  newf;
  logic [7:0]  upd;
  logic        bus_wr_ok;

  always_comb begin
    n         = q;
    n.done    = 1'b0;
    opa       = rd_data[0];
    opb       = rd_data[1];
    cf        = q.flags[`BAO_FLAG_C];
    res       = opa;
    ar        = '0;
    w16       = {rd_data[1], rd_data[0]};
    w17       = '0;
    prod      = '0;
    newf      = '0;
    upd       = '0;
    wr_en     = 1'b0;
    wr_idx    = q.dst;
    wr_data   = '0;
    bus_wr_ok = 1'b1;

    unique case (q.st)
      ST_IDLE: begin
        if (OP_START) begin
          n.op  = bao_op_type'(OP_CODE);
          n.dst = OP_DST;
          n.imm = OP_IMM;
          n.st  = ST_EXEC;
        end
      end

      ST_EXEC: begin
        bus_wr_ok = 1'b0;
        wr_en     = 1'b1;
        n.st      = ST_IDLE;
        n.done    = 1'b1;
        n.cycles  = `BAO_CYC_ONE;
        case (q.op)
          OP_PLUS_TWO_REGS: begin
            ar = add8(opa, opb, 1'b0);
          end
          OP_PLUS_WITH_CARRY_IN: begin
            ar = add8(opa, opb, cf);
          end
          OP_MINUS_TWO_REGS: begin
            ar = sub8(opa, opb, 1'b0);
          end
          OP_MINUS_IMM: begin
            ar = sub8(opa, q.imm, 1'b0);
          end
          OP_MINUS_WITH_BORROW: begin
            ar = sub8(opa, opb, cf);
          end
          OP_MINUS_IMM_WITH_BORROW: begin
            ar = sub8(opa, q.imm, cf);
          end
          OP_TWOS_INVERT: begin
            ar = sub8(`BAO_ZERO_BYTE, opa, 1'b0);
          end
          default: begin
            ar = '0;
          end
        endcase

        case (q.op)
          OP_PLUS_TWO_REGS, OP_PLUS_WITH_CARRY_IN, OP_MINUS_TWO_REGS,
          OP_MINUS_IMM, OP_MINUS_WITH_BORROW, OP_MINUS_IMM_WITH_BORROW,
          OP_TWOS_INVERT: begin
            res                 = ar[7:0];
            newf[`BAO_FLAG_C]   = ar[8];
            newf[`BAO_FLAG_V]   = ar[9];
            newf[`BAO_FLAG_H]   = ar[10];
            upd[`BAO_FLAG_C]    = 1'b1;
            upd[`BAO_FLAG_H]    = 1'b1;
          end
          OP_BITWISE_CONJ:     res = opa & opb;
          OP_BITWISE_CONJ_IMM: res = opa & q.imm;
          OP_BITWISE_DISJ:     res = opa | opb;
          OP_BITWISE_DISJ_IMM: res = opa | q.imm;
          OP_BITWISE_XDISJ:    res = opa ^ opb;
          OP_SELF_XDISJ_ZERO:  res = opa ^ opa;
          OP_BIT_SET_MASK:     res = opa | q.imm;
          OP_BIT_CLEAR_MASK: begin
            res = opa & (`BAO_ALL_ONES - q.imm);
          end
          OP_ZERO_SIGN_PROBE:  res = opa & opa;
          OP_ONES_INVERT: begin
            res               = `BAO_ALL_ONES - opa;
            newf[`BAO_FLAG_C] = 1'b1;
            upd[`BAO_FLAG_C]  = 1'b1;
          end
          OP_PLUS_ONE: begin
            res               = opa + `BAO_ONE_BYTE;
            newf[`BAO_FLAG_V] = (res == `BAO_SIGN_MIN);
          end
          OP_MINUS_ONE: begin
            res               = opa - `BAO_ONE_BYTE;
            newf[`BAO_FLAG_V] = (res == `BAO_SIGN_MAX);
          end
          OP_ALL_ONES_LOAD: begin
            res = `BAO_ALL_ONES;
          end
          OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM: begin
            if (q.op == OP_WORD_PLUS_IMM) begin
              w17 = {1'b0, w16} + {9'h000, q.imm};
              newf[`BAO_FLAG_V] = ~w16[15] & w17[15];
            end else begin
              w17 = {1'b0, w16} - {9'h000, q.imm};
              newf[`BAO_FLAG_V] = w16[15] & ~w17[15];
            end
            res               = w17[7:0];
            newf[`BAO_FLAG_C] = w17[16];
            newf[`BAO_FLAG_Z] = (w17[15:0] == 16'h0000);
            newf[`BAO_FLAG_N] = w17[15];
            newf[`BAO_FLAG_S] = w17[15] ^ newf[`BAO_FLAG_V];
            upd[`BAO_FLAG_C]  = 1'b1;
            upd[`BAO_FLAG_S]  = 1'b1;
            n.hi_idx          = q.dst + `BAO_IDX_W'(1);
            n.hi_byte         = w17[15:8];
            n.st              = ST_EXEC2;
            n.done            = 1'b0;
          end
          OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT: begin
            // Factors are widened to the product width first, so that the
            // sign survives no matter how the multiply is sized.
            if (q.op == OP_SIGNED_PRODUCT) begin
              prod = $signed({{8{opa[7]}}, opa}) *
                     $signed({{8{opb[7]}}, opb});
            end else begin
              prod = {8'h00, opa} * {8'h00, opb};
            end
            res               = prod[7:0];
            wr_idx            = `BAO_PROD_LO;
            newf[`BAO_FLAG_C] = prod[15];
            newf[`BAO_FLAG_Z] = (prod == 16'h0000);
            upd[`BAO_FLAG_C]  = 1'b1;
            n.hi_idx          = `BAO_PROD_HI;
            n.hi_byte         = prod[15:8];
            n.st              = ST_EXEC2;
            n.done            = 1'b0;
          end
          default: begin
            // Unknown codes retire in one cycle with no effect.
            wr_en    = 1'b0;
            n.cycles = `BAO_CYC_NONE;
          end
        endcase

        // Byte results share the zero and sign rules; every byte-result
        // operation except the all-ones load touches Z, N and V.
        if (!is_pair_op(q.op) && (q.op != OP_UNSIGNED_PRODUCT) &&
            (q.op != OP_SIGNED_PRODUCT) && (q.op != OP_ALL_ONES_LOAD) &&
            wr_en) begin
          newf[`BAO_FLAG_Z] = (res == `BAO_ZERO_BYTE);
          newf[`BAO_FLAG_N] = res[7];
          upd[`BAO_FLAG_Z]  = 1'b1;
          upd[`BAO_FLAG_N]  = 1'b1;
          upd[`BAO_FLAG_V]  = 1'b1;
        end
        if (is_pair_op(q.op)) begin
          upd[`BAO_FLAG_Z] = 1'b1;
          upd[`BAO_FLAG_N] = 1'b1;
          upd[`BAO_FLAG_V] = 1'b1;
        end
        if ((q.op == OP_UNSIGNED_PRODUCT) || (q.op == OP_SIGNED_PRODUCT)) begin
          upd[`BAO_FLAG_Z] = 1'b1;
        end
        wr_data = res;
      end

      ST_EXEC2: begin
        // High byte of a pair result; the flags were settled a cycle ago.
        bus_wr_ok = 1'b0;
        wr_en     = 1'b1;
        wr_idx    = q.hi_idx;
        wr_data   = q.hi_byte;
        n.st      = ST_IDLE;
        n.done    = 1'b1;
        n.cycles  = `BAO_CYC_TWO;
      end

      default: begin
        n.st = ST_IDLE;
      end
    endcase

    // Software writes to the working registers share the single write port
    // and lose to an operation's write-back in the same cycle.
    if (REG_WR && is_work_addr(REG_ADDR) && bus_wr_ok) begin
      wr_en   = 1'b1;
      wr_idx  = REG_ADDR[`BAO_IDX_W-1:0];
      wr_data = REG_WDATA;
    end

    // A flag write from software is overridden bit by bit by hardware.
    if (REG_WR && (REG_ADDR == `BAO_ADDR_FLAGS)) begin
      n.flags = REG_WDATA & `BAO_FLAGS_WMASK;
    end
    n.flags = (n.flags & ~upd) | (newf & upd);

    n.rd_mem  = REG_RD && is_work_addr(REG_ADDR);
    n.rd_byte = '0;
    if (REG_RD && (REG_ADDR == `BAO_ADDR_FLAGS)) begin
      n.rd_byte = q.flags;
    end
    if (REG_RD && (REG_ADDR == `BAO_ADDR_STATUS)) begin
      n.rd_byte[`BAO_STAT_BUSY] = (q.st != ST_IDLE);
      n.rd_byte[`BAO_STAT_CYC_HI:`BAO_STAT_CYC_LO] = q.cycles;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      q         <= '0;
      q.st      <= ST_IDLE;
      q.op      <= OP_PLUS_TWO_REGS;
      q.flags   <= `BAO_FLAGS_RST;
      q.cycles  <= `BAO_CYC_NONE;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign OP_READY  = (q.st == ST_IDLE);
  assign OP_DONE   = q.done;
  assign OP_CYCLES = q.cycles;
  assign REG_RDATA = q.rd_mem ? rd_data[2] : q.rd_byte;
  assign FLAGS     = q.flags;

endmodule : bao_alu

// ===== testbench/bao_alu_properties.sv
`include "bao_defs.svh"

module bao_alu_properties
  import bao_pkg::*;
(
  // Clock and reset.
  input wire logic                   MCLK,
  input wire logic                   RST,
  // Operation port.
  input wire logic                   OP_START,
  input wire logic [4:0]             OP_CODE,
  input wire logic [`BAO_IDX_W-1:0]  OP_DST,
  input wire logic [`BAO_IDX_W-1:0]  OP_SRC,
  input wire logic [`BAO_DATA_W-1:0] OP_IMM,
  input wire logic                   OP_READY,
  input wire logic                   OP_DONE,
  input wire logic [1:0]             OP_CYCLES,
  // Register port and flags.
  input wire logic [`BAO_ADDR_W-1:0] REG_ADDR,
  input wire logic [`BAO_DATA_W-1:0] REG_WDATA,
  input wire logic                   REG_WR,
  input wire logic                   REG_RD,
  input wire logic [`BAO_DATA_W-1:0] REG_RDATA,
  input wire logic [`BAO_DATA_W-1:0] FLAGS
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       take;
  logic       prod;
  logic       two_cyc;
  logic       known;
  logic       logic_op;
  logic [3:0] upper_flags;

  assign take        = OP_START && OP_READY;
  assign prod        = OP_CODE inside {OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT};
  assign two_cyc     = prod || (OP_CODE inside {OP_WORD_PLUS_IMM,
                                                OP_WORD_MINUS_IMM});
  assign known       = OP_CODE <= OP_SIGNED_PRODUCT;
  assign logic_op    = OP_CODE inside {[OP_BITWISE_CONJ:OP_BITWISE_XDISJ],
                                       OP_BIT_SET_MASK, OP_BIT_CLEAR_MASK,
                                       OP_ZERO_SIGN_PROBE, OP_SELF_XDISJ_ZERO};
  assign upper_flags = FLAGS[5:2];

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////////
  chk_one_cycle: assert property (
    take && known && !two_cyc |=> !OP_DONE ##1 OP_DONE && OP_CYCLES == 2'h1)
    else $error("single cycle operation retired at the wrong time");
  chk_two_cycle: assert property (
    take && two_cyc |=> !OP_DONE[*2] ##1 OP_DONE && OP_CYCLES == 2'h2)
    else $error("two cycle operation retired at the wrong time");
  chk_busy_low: assert property (
    take |=> !OP_READY)
    else $error("ready stayed high after an accepted request");
  chk_done_ready: assert property (
    OP_DONE |-> OP_READY && !$past(OP_READY))
    else $error("done without a preceding busy phase");
  chk_done_pulse: assert property (
    OP_DONE |=> !OP_DONE)
    else $error("done held longer than one cycle");
  chk_logic_ovf: assert property (
    take && logic_op |-> ##2 !FLAGS[`BAO_FLAG_V])
    else $error("logic operation left overflow set");
  chk_load_flags: assert property (
    take && OP_CODE == OP_ALL_ONES_LOAD |=> $stable(FLAGS)[*2])
    else $error("all ones load changed the flags");
  chk_prod_flags: assert property (
    take && prod |-> ##3 upper_flags == $past(upper_flags, 3))
    else $error("product touched flags other than zero and carry");
  chk_word_sign: assert property (
    take && two_cyc && !prod |-> ##3
      FLAGS[`BAO_FLAG_S] == (FLAGS[`BAO_FLAG_N] ^ FLAGS[`BAO_FLAG_V]))
    else $error("word operation sign flag inconsistent");

  cov_word_op: cover property (take && two_cyc && !prod);
  cov_product: cover property (take && OP_CODE == OP_SIGNED_PRODUCT);
  cov_reg_read: cover property (REG_RD ##1 REG_RDATA != 8'h00);
endmodule : bao_alu_properties

bind bao_alu bao_alu_properties u_props (
  .MCLK(MCLK), .RST(RST), .OP_START(OP_START), .OP_CODE(OP_CODE),
  .OP_DST(OP_DST), .OP_SRC(OP_SRC), .OP_IMM(OP_IMM), .OP_READY(OP_READY),
  .OP_DONE(OP_DONE), .OP_CYCLES(OP_CYCLES), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .FLAGS(FLAGS)
);

// ===== testbench/bao_decoder_model.sv
`include "bao_defs.svh"

module bao_decoder_model
  import bao_pkg::*;
(
  // Clock.
  input wire logic                   clk,
  // Request to the datapath.
  output logic                       start,
  output logic [4:0]                 code,
  output logic [`BAO_IDX_W-1:0]      dst,
  output logic [`BAO_IDX_W-1:0]      src,
  output logic [`BAO_DATA_W-1:0]     imm,
  // Datapath status.
  input wire logic                   ready
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    start = 1'b0;
    code  = 5'h1f;
    dst   = 5'h1f;
    src   = 5'h1f;
    imm   = 8'hff;
  end

  // Fields are inverted once released, so a datapath that samples late
  // picks up garbage instead of a conveniently held value.
  task automatic issue(input logic [4:0] c, input logic [4:0] d,
                       input logic [4:0] s, input logic [7:0] i);
    logic r;
    @(posedge clk);
    start <= 1'b1;
    code  <= c;
    dst   <= d;
    src   <= s;
    imm   <= i;
    do begin
      @(negedge clk);
      r = ready;
      @(posedge clk);
    end while (r !== 1'b1);
    start <= 1'b0;
    code  <= ~c;
    dst   <= ~d;
    src   <= ~s;
    imm   <= ~i;
  endtask : issue
endmodule : bao_decoder_model

// ===== testbench/bao_alu_tb.sv
module bao_alu_tb
  import bao_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       mclk      = 1'b0;
  logic       rst       = 1'b1;
  logic [5:0] reg_addr  = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       op_start;
  logic [4:0] op_code;
  logic [4:0] op_dst;
  logic [4:0] op_src;
  logic [7:0] op_imm;
  logic       op_ready;
  logic       op_done;
  logic [1:0] op_cycles;
  logic [7:0] reg_rdata;
  logic [7:0] flags;
  logic [7:0] rd;
  int         miscompares = 0;
  int         n_tests     = 0;

  always #12.5 mclk = ~mclk;

  bao_alu DUT (
    .MCLK(mclk), .RST(rst), .OP_START(op_start), .OP_CODE(op_code),
    .OP_DST(op_dst), .OP_SRC(op_src), .OP_IMM(op_imm), .OP_READY(op_ready),
    .OP_DONE(op_done), .OP_CYCLES(op_cycles), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .FLAGS(flags)
  );

  bao_decoder_model u_dec (
    .clk(mclk), .start(op_start), .code(op_code), .dst(op_dst),
    .src(op_src), .imm(op_imm), .ready(op_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wreg(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rreg

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // Operands sit in r4 and r5; r5 doubles as the immediate and as the high
  // byte of a word, which keeps every case on one line. Overflow is preset,
  // so an operation that must clear it is seen to do so.
  task automatic t(input bao_op_type c, input logic [7:0] a,
                   input logic [7:0] b, input logic ci,
                   input logic [15:0] e, input logic [5:0] fv);
    int         n;
    logic       prod;
    logic       two;
    logic [1:0] cyc;
    logic [7:0] lo;
    logic [7:0] hi;
    prod = c inside {OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT};
    two  = prod || (c inside {OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM});
    cyc  = (c > OP_SIGNED_PRODUCT) ? 2'h0 : (two ? 2'h2 : 2'h1);
    wreg(6'h04, a);
    wreg(6'h05, b);
    wreg(6'h20, {4'h0, 1'b1, 2'h0, ci});
    u_dec.issue(c, 5'h04, 5'h05, b);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (op_done !== 1'b1 && n < 8);
    check(16'(n), two ? 16'h0002 : 16'h0001);
    check({14'h0000, op_cycles}, {14'h0000, cyc});
    check({15'h0000, op_ready}, 16'h0001);
    rreg(prod ? 6'h00 : 6'h04, lo);
    rreg(prod ? 6'h01 : 6'h05, hi);
    check(two ? {hi, lo} : {8'h00, lo}, e);
    rreg(6'h20, lo);
    check({8'h00, lo}, {10'h000, fv});
    check({8'h00, flags}, {10'h000, fv});
    $display("test of operation %h finished", c);
  endtask : t

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rreg(6'h20, rd);
    check({8'h00, rd}, 16'h0000);
    wreg(6'h07, 8'ha5);
    rreg(6'h07, rd);
    check({8'h00, rd}, 16'h00a5);
    wreg(6'h20, 8'hff);
    rreg(6'h20, rd);
    check({8'h00, rd}, 16'h003f);
    wreg(6'h3f, 8'h5a);
    rreg(6'h3f, rd);
    check({8'h00, rd}, 16'h0000);
    wreg(6'h21, 8'hff);
    rreg(6'h21, rd);
    check({8'h00, rd}, 16'h0000);
    $display("register port test finished");
    t(OP_PLUS_TWO_REGS, 8'h3c, 8'h0f, 1'b0, 16'h004b, 6'h20);
    t(OP_PLUS_WITH_CARRY_IN, 8'hff, 8'h00, 1'b1, 16'h0000, 6'h23);
    t(OP_WORD_PLUS_IMM, 8'hff, 8'h7f, 1'b0, 16'h807e, 6'h0c);
    t(OP_MINUS_TWO_REGS, 8'h10, 8'h20, 1'b0, 16'h00f0, 6'h05);
    t(OP_MINUS_IMM, 8'h80, 8'h01, 1'b0, 16'h007f, 6'h28);
    t(OP_MINUS_WITH_BORROW, 8'h05, 8'h05, 1'b1, 16'h00ff, 6'h25);
    t(OP_MINUS_IMM_WITH_BORROW, 8'h01, 8'h00, 1'b1, 16'h0, 6'h02);
    t(OP_WORD_MINUS_IMM, 8'h10, 8'h80, 1'b0, 16'h7f90, 6'h18);
    t(OP_BITWISE_CONJ, 8'hf0, 8'h3c, 1'b1, 16'h0030, 6'h01);
    t(OP_BITWISE_CONJ_IMM, 8'h0f, 8'hf0, 1'b0, 16'h0000, 6'h02);
    t(OP_BITWISE_DISJ, 8'h80, 8'h01, 1'b1, 16'h0081, 6'h05);
    t(OP_BITWISE_DISJ_IMM, 8'h00, 8'h00, 1'b0, 16'h0000, 6'h02);
    t(OP_BITWISE_XDISJ, 8'haa, 8'hff, 1'b0, 16'h0055, 6'h00);
    t(OP_SELF_XDISJ_ZERO, 8'h5a, 8'h00, 1'b0, 16'h0000, 6'h02);
    t(OP_BIT_SET_MASK, 8'h10, 8'h81, 1'b0, 16'h0091, 6'h04);
    t(OP_BIT_CLEAR_MASK, 8'hff, 8'h0f, 1'b1, 16'h00f0, 6'h05);
    t(OP_ZERO_SIGN_PROBE, 8'h90, 8'h00, 1'b1, 16'h0090, 6'h05);
    t(OP_ONES_INVERT, 8'h00, 8'h00, 1'b0, 16'h00ff, 6'h05);
    t(OP_TWOS_INVERT, 8'h01, 8'h00, 1'b0, 16'h00ff, 6'h25);
    t(OP_PLUS_ONE, 8'h7f, 8'h00, 1'b1, 16'h0080, 6'h0d);
    t(OP_MINUS_ONE, 8'h80, 8'h00, 1'b0, 16'h007f, 6'h08);
    t(OP_ALL_ONES_LOAD, 8'h12, 8'h00, 1'b1, 16'h00ff, 6'h09);
    t(OP_UNSIGNED_PRODUCT, 8'hff, 8'hff, 1'b0, 16'hfe01, 6'h09);
    t(OP_UNSIGNED_PRODUCT, 8'h00, 8'h37, 1'b1, 16'h0000, 6'h0a);
    t(OP_SIGNED_PRODUCT, 8'h80, 8'h01, 1'b0, 16'hff80, 6'h09);
    rreg(6'h21, rd);
    check({8'h00, rd}, 16'h0004);
    t(bao_op_type'(5'h18), 8'h33, 8'h00, 1'b1, 16'h0033, 6'h09);
    rreg(6'h21, rd);
    check({8'h00, rd}, 16'h0000);
    give_verdict;
  end

  // The whole sequence needs well under a thousand cycles.
  initial begin
    #100000;
    miscompares++;
    give_verdict;
  end
endmodule : bao_alu_tb
